// ==== verilog/frs_pkg.sv ====
// Constants for the fault retry sequencer.
// Assumes a 10 MHz system clock and a delay unit given in clock ticks.
package frs_pkg;
  localparam int unsigned SYS_CLK_HZ   = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  // Response field positions inside the 8-bit setting
  localparam int unsigned RESP_MSB     = 7;
  localparam int unsigned RESP_LSB     = 6;
  localparam int unsigned RETRY_MSB    = 5;
  localparam int unsigned RETRY_LSB    = 3;
  localparam int unsigned DELAY_MSB    = 2;
  localparam int unsigned DELAY_LSB    = 0;
  // Response codes
  localparam logic [1:0]  RESP_IGNORE  = 2'h0;
  localparam logic [1:0]  RESP_RUN_ON  = 2'h1;
  localparam logic [1:0]  RESP_RETRY   = 2'h2;
  localparam logic [1:0]  RESP_LATCH   = 2'h3;
  // Retry-count codes
  localparam logic [2:0]  RETRY_NONE   = 3'h0;
  localparam logic [2:0]  RETRY_ENDLESS = 3'h7;
  // Reset values
  localparam logic [7:0]  SETTING_RST  = 8'h00;
  localparam logic [15:0] UNIT_RST     = 16'h0001;
  // Delay code gives 2**code time units
  localparam int unsigned DELAY_CNT_W  = 24;
  localparam int unsigned ATTEMPT_W    = 3;

  typedef enum logic [2:0] {
    FRS_RUN   = 3'b000,
    FRS_RUNON = 3'b001,
    FRS_OFF   = 3'b011,
    FRS_TRY   = 3'b010,
    FRS_LATCH = 3'b110
  } frs_state_type;
endpackage

// ==== verilog/frs_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module frs_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;
      end
    end
  end

  assign sync_out = out_r;
endmodule
`default_nettype wire

// ==== verilog/frs_sequencer.sv ====
// Output under-voltage fault response and retry sequencer.
// Assumes setting and unit come from a host-written register; fault,
// enable pin are asynchronous, other strobes are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: codes 2..6 give that many restarts
// R2: after last failed try, latch off
// R3: attempt spacing is 2**delay field times unit
// R4: code 7 retries until commanded off
// R5: other fault shutdown ends endless retrying
// R6: response field picks one of four behaviours
// R7: code 0 means no restart, latch off
// R8: status clear, clear-all, off-on, power clear
// R9: delay code n gives 2**n time units
// R10: attempt counter resets on clear or recovery
module frs_sequencer
  import frs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  resp_setting,
  input  wire logic [15:0] unit_ticks,
  input  wire logic        uv_fault_pin,
  input  wire logic        ctrl_pin,
  input  wire logic        op_on,
  input  wire logic        clear_status,
  input  wire logic        clear_faults,
  input  wire logic        other_fault_stop,
  output var  logic        output_en,
  output var  logic        fault_latched,
  output var  logic        retrying,
  output var  logic [2:0]  attempts_used
);
  logic          uv_s;
  logic          ctrl_s;
  frs_state_type st_r;
  frs_state_type st_nxt;
  logic [DELAY_CNT_W-1:0] tmr_r;
  logic [DELAY_CNT_W-1:0] tmr_nxt;
  logic [ATTEMPT_W-1:0]   cnt_r;
  logic [ATTEMPT_W-1:0]   cnt_nxt;
  logic          on_prev_r;
  logic          en_r;
  logic          lat_r;
  logic          try_r;

  frs_sync u_sync_uv (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (uv_fault_pin),
    .sync_out (uv_s)
  );
  frs_sync u_sync_ctrl (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (ctrl_pin),
    .sync_out (ctrl_s)
  );

  // Delay in clock ticks: 2**code units
  function automatic logic [DELAY_CNT_W-1:0] delay_ticks(
    input logic [2:0]  code,
    input logic [15:0] unit
  );
    logic [DELAY_CNT_W-1:0] u;
    u = DELAY_CNT_W'(unit);
    delay_ticks = DELAY_CNT_W'(u << code); // R9
  endfunction

  wire logic [1:0] resp_w   = resp_setting[RESP_MSB:RESP_LSB];
  wire logic [2:0] retry_w  = resp_setting[RETRY_MSB:RETRY_LSB];
  wire logic [2:0] dcode_w  = resp_setting[DELAY_MSB:DELAY_LSB];
  wire logic [DELAY_CNT_W-1:0] dly_w = delay_ticks(dcode_w, unit_ticks);
  // Reload one short so a full interval is exactly dly_w ticks
  wire logic [DELAY_CNT_W-1:0] dly_load_w = (dly_w == '0) ? '0 :
                                            dly_w - 1'b1; // R3
  wire logic on_cmd_w  = ctrl_s & op_on;
  wire logic off_on_w  = on_cmd_w & ~on_prev_r;
  wire logic clear_w   = clear_status | clear_faults | off_on_w; // R8
  wire logic endless_w = (retry_w == RETRY_ENDLESS); // R4
  // Codes 1..6 allow that many tries; 7 never runs out
  wire logic tries_left_w = endless_w ? 1'b1 :
                            (cnt_r < retry_w); // R1
  wire logic tmr_done_w = (tmr_r == '0);

  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_done_w ? tmr_r : tmr_r - 1'b1;
    cnt_nxt = cnt_r;
    case (st_r)
      FRS_RUN: begin
        cnt_nxt = '0; // R10
        if (uv_s && on_cmd_w && !other_fault_stop) begin // R5
          case (resp_w) // R6
            RESP_IGNORE: st_nxt = FRS_RUN;
            RESP_RUN_ON: begin
              st_nxt  = FRS_RUNON;
              tmr_nxt = dly_load_w;
            end
            RESP_RETRY: begin
              st_nxt  = (retry_w == RETRY_NONE) ? FRS_LATCH : FRS_OFF; // R7
              tmr_nxt = dly_load_w;
            end
            default: st_nxt = FRS_LATCH;
          endcase
        end
      end
      FRS_RUNON: begin
        if (!uv_s) begin
          st_nxt = FRS_RUN;
        end else if (tmr_done_w) begin
          st_nxt  = (retry_w == RETRY_NONE) ? FRS_LATCH : FRS_OFF; // R7
          tmr_nxt = dly_load_w;
        end
      end
      FRS_OFF: begin
        if (tmr_done_w) begin
          if (tries_left_w) begin
            st_nxt  = FRS_TRY;
            tmr_nxt = dly_load_w; // R3
            cnt_nxt = endless_w ? cnt_r : cnt_r + 1'b1;
          end else begin
            st_nxt = FRS_LATCH; // R2
          end
        end
      end
      FRS_TRY: begin
        if (!uv_s) begin
          st_nxt = FRS_RUN; // R10
        end else if (tmr_done_w) begin
          if (tries_left_w) begin
            tmr_nxt = dly_load_w; // R3
            cnt_nxt = endless_w ? cnt_r : cnt_r + 1'b1;
          end else begin
            st_nxt = FRS_LATCH; // R2
          end
        end
      end
      FRS_LATCH: begin
        if (clear_w) begin
          st_nxt  = FRS_RUN;
          cnt_nxt = '0; // R10
        end
      end
      default: st_nxt = FRS_RUN;
    endcase
    // Command off or a foreign shutdown ends retrying
    if ((st_r == FRS_OFF || st_r == FRS_TRY) &&
        (!on_cmd_w || other_fault_stop)) begin // R4 R5
      st_nxt  = FRS_RUN;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r      <= FRS_RUN;
      tmr_r     <= '0;
      cnt_r     <= '0;
      on_prev_r <= 1'b0;
      en_r      <= 1'b0;
      lat_r     <= 1'b0;
      try_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      tmr_r     <= tmr_nxt;
      cnt_r     <= cnt_nxt;
      on_prev_r <= on_cmd_w;
      en_r      <= on_cmd_w && (st_nxt != FRS_OFF) &&
                   (st_nxt != FRS_LATCH); // R2
      lat_r     <= (st_nxt == FRS_LATCH);
      try_r     <= (st_nxt == FRS_OFF) || (st_nxt == FRS_TRY);
    end
  end

  assign output_en     = en_r;
  assign fault_latched = lat_r;
  assign retrying      = try_r;
  assign attempts_used = cnt_r;

  // Checks
  property p_latch_off;
    @(posedge sys_clk) disable iff (reset)
      fault_latched |-> !output_en;
  endproperty
  a_latch_off: assert property (p_latch_off) // R2
    else $error("output enabled while latched");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (reset)
      (st_r == FRS_LATCH && !clear_w) |=> (st_r == FRS_LATCH);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // R8
    else $error("latch left without clear");

  property p_count_limit;
    @(posedge sys_clk) disable iff (reset)
      (!endless_w && retry_w != RETRY_NONE) |-> (cnt_r <= retry_w);
  endproperty
  a_count_limit: assert property (p_count_limit) // R1
    else $error("attempt count beyond setting");

  property p_no_retry;
    @(posedge sys_clk) disable iff (reset)
      (st_r != FRS_OFF && st_r != FRS_TRY && retry_w == RETRY_NONE &&
       st_nxt == FRS_OFF) |-> 1'b0;
  endproperty
  a_no_retry: assert property (p_no_retry) // R7
    else $error("retry entered with code zero");

  property p_endless;
    @(posedge sys_clk) disable iff (reset)
      (st_r == FRS_TRY && endless_w && uv_s && on_cmd_w &&
       !other_fault_stop) |=> (st_r != FRS_LATCH);
  endproperty
  a_endless: assert property (p_endless) // R4
    else $error("endless retry latched");

  property p_stop;
    @(posedge sys_clk) disable iff (reset)
      ((st_r == FRS_OFF || st_r == FRS_TRY) && other_fault_stop)
        |=> (st_r == FRS_RUN && cnt_r == '0);
  endproperty
  a_stop: assert property (p_stop) // R5
    else $error("foreign shutdown did not stop retry");

  property p_cnt_reset;
    @(posedge sys_clk) disable iff (reset)
      (st_r == FRS_RUN) |=> (st_r != FRS_RUN || cnt_r == '0);
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) // R10
    else $error("attempt counter kept after recovery");

  property p_spacing;
    @(posedge sys_clk) disable iff (reset)
      (st_r == FRS_OFF && st_nxt == FRS_TRY) |=> (tmr_r == dly_load_w);
  endproperty
  a_spacing: assert property (p_spacing) // R3
    else $error("attempt spacing wrong");

  property p_ignore;
    @(posedge sys_clk) disable iff (reset)
      (st_r == FRS_RUN && resp_w == RESP_IGNORE) |=> (st_r == FRS_RUN);
  endproperty
  a_ignore: assert property (p_ignore) // R6
    else $error("ignore response acted");

  c_latch: cover property (@(posedge sys_clk) st_r == FRS_LATCH);
  c_try:   cover property (@(posedge sys_clk) st_r == FRS_TRY);
  c_runon: cover property (@(posedge sys_clk) st_r == FRS_RUNON);
  c_recov: cover property (@(posedge sys_clk)
                           st_r == FRS_TRY ##1 st_r == FRS_RUN);
endmodule
`default_nettype wire

// ==== verif/frs_host_model.sv ====
// Host-side model: holds the fault response settings and clear strobes.
// Assumes the bench calls its tasks from the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module frs_host_model (
  input  wire logic        sys_clk,
  output var  logic [7:0]  resp_setting,
  output var  logic [15:0] unit_ticks,
  output var  logic        op_on,
  output var  logic        clear_status,
  output var  logic        clear_faults
);
  initial begin
    resp_setting = 8'h00;
    unit_ticks   = 16'h0002;
    op_on        = 1'b1;
    clear_status = 1'b0;
    clear_faults = 1'b0;
  end
  // Setting change just after an edge
  task automatic put(input logic [7:0] s);
    @(posedge sys_clk) #1 resp_setting = s;
  endtask
  // One-cycle clear strobe, either kind
  task automatic clr(input logic all);
    @(posedge sys_clk) #1;
    if (all)
      clear_faults = 1'b1;
    else
      clear_status = 1'b1;
    @(posedge sys_clk) #1;
    clear_faults = 1'b0;
    clear_status = 1'b0;
  endtask
  // On command level
  task automatic op(input logic v);
    @(posedge sys_clk) #1 op_on = v;
  endtask
endmodule
`default_nettype wire

// ==== verif/fault_retry_sequencer_bench.sv ====
// Bench for the fault retry sequencer.
// Assumes unit_ticks 2, so delay code 2 spaces attempts 8 cycles apart.
`timescale 1ns/100ps
`default_nettype none
module fault_retry_sequencer_bench
  import frs_pkg::*;
;
  logic       sys_clk, reset, uv, ctrl, oth;
  logic [7:0] st;
  logic [15:0] ut;
  logic       op, cs, cf, oe, fl, rt;
  logic [2:0] au;
  int         n_mismatch, checks_done;

  frs_host_model hm (.sys_clk(sys_clk), .resp_setting(st),
    .unit_ticks(ut), .op_on(op), .clear_status(cs), .clear_faults(cf));
  frs_sequencer uut (.sys_clk(sys_clk), .reset(reset),
    .resp_setting(st), .unit_ticks(ut), .uv_fault_pin(uv),
    .ctrl_pin(ctrl), .op_on(op), .clear_status(cs),
    .clear_faults(cf), .other_fault_stop(oth), .output_en(oe),
    .fault_latched(fl), .retrying(rt), .attempts_used(au));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Waits a bounded time for the latched-off state
  task automatic wlat(input int lim, output int t);
    t = 0;
    while (fl !== 1'b1 && t < lim) begin
      cyc(1);
      t++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end

  initial begin
    int t;
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    uv = 1'b0;
    ctrl = 1'b1;
    oth = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    cyc(8);
    chk("output_en", 1, oe);
    // Counted retries, each clear kind in turn
    for (int n = 2; n <= 6; n++) begin
      hm.put({RESP_RETRY, n[2:0], 3'h2});
      cyc(1);
      uv = 1'b1;
      wlat(200, t);
      chk("fault_latched", 1, fl);
      chk("output_en", 0, oe);
      chk("attempts_used", n, au);
      chk("spacing", 1, t >= (n+1)*8+4 && t <= (n+1)*8+6);
      uv = 1'b0;
      cyc(6);
      hm.clr(n[0]);
      cyc(2);
      chk("fault_latched", 0, fl);
      chk("attempts_used", 0, au);
      chk("output_en", 1, oe);
    end
    // No retry, cleared by off-on command
    hm.put({RESP_RETRY, RETRY_NONE, 3'h2});
    cyc(1);
    uv = 1'b1;
    wlat(20, t);
    chk("fault_latched", 1, fl);
    chk("attempts_used", 0, au);
    uv = 1'b0;
    cyc(6);
    hm.op(0);
    hm.op(1);
    cyc(2);
    chk("fault_latched", 0, fl);
    // Latch response, cleared by pin off-on
    hm.put({RESP_LATCH, 3'h7, 3'h2});
    cyc(1);
    uv = 1'b1;
    wlat(20, t);
    chk("fault_latched", 1, fl);
    uv = 1'b0;
    cyc(6);
    ctrl = 1'b0;
    cyc(6);
    ctrl = 1'b1;
    cyc(8);
    chk("fault_latched", 0, fl);
    chk("output_en", 1, oe);
    // Ignore response
    hm.put({RESP_IGNORE, 3'h2, 3'h2});
    cyc(1);
    uv = 1'b1;
    cyc(40);
    chk("output_en", 1, oe);
    chk("retrying", 0, rt);
    // Run on for the delay, then retry
    hm.put({RESP_RUN_ON, 3'h2, 3'h2});
    cyc(6);
    chk("output_en", 1, oe);
    wlat(100, t);
    chk("fault_latched", 1, fl);
    uv = 1'b0;
    cyc(6);
    hm.clr(1);
    // Endless retrying, ended by off command and by another fault
    hm.put({RESP_RETRY, RETRY_ENDLESS, 3'h1});
    cyc(1);
    uv = 1'b1;
    cyc(120);
    chk("fault_latched", 0, fl);
    chk("retrying", 1, rt);
    hm.op(0);
    cyc(3);
    chk("retrying", 0, rt);
    hm.op(1);
    cyc(20);
    chk("retrying", 1, rt);
    oth = 1'b1;
    cyc(3);
    chk("retrying", 0, rt);
    cyc(1);
    chk("retrying", 0, rt);
    uv = 1'b0;
    cyc(6);
    oth = 1'b0;
    // Recovery mid-retry restores the output and the count
    hm.put({RESP_RETRY, 3'h3, 3'h2});
    cyc(4);
    uv = 1'b1;
    cyc(20);
    chk("retrying", 1, rt);
    chk("attempts_used", 1, au);
    uv = 1'b0;
    cyc(16);
    chk("output_en", 1, oe);
    chk("attempts_used", 0, au);
    close_out();
  end
endmodule
`default_nettype wire
